// *** emb_mult_regs.svh ***
`ifndef EMB_MULT_REGS_SVH
`define EMB_MULT_REGS_SVH

// operand section widths
`define MUL_SECT_W 9
`define MUL_FULL_W 18
// result widths: two sections in dual mode, one full word in single mode
`define MUL_HALF_RES_W 18
`define MUL_FULL_RES_W 36
// bit positions of the second section
`define MUL_SECT_HI_LSB 9
`define MUL_RES_HI_LSB 18
// single mode serves operands of at least this width
`define MUL_SINGLE_MIN_W 10
// value every block register takes on clear
`define MUL_CLR_VAL 36'h0

`endif

// *** emb_mult_pkg.sv ***
package emb_mult_pkg;

	typedef enum logic [0:0]
	{
		MODE_SINGLE = 1'b0,
		MODE_DUAL = 1'b1
	} mul_mode_t;

	typedef logic [35:0] mul_result_t;

endpackage

// *** embedded_multiplier_block.sv ***
`timescale 1ns/1ps
// Summary of operation
// - one 18x18 or two independent 9x9 multipliers
// - operand widths between 1 and 18 accepted
// - operands enter in 9/18-bit sections, registered or direct
// - each operand registered or bypassed independently
// - one clock, enable and clear for all
// - sign select high means operand is signed
// - product signed when any operand signed
// - one sign select per side, shared in dual
// - sign selects may change at run time
// - each sign select has optional input register
// - full precision product, never truncated or rounded
// - optional output register in 18/36-bit sections
// - unconnected sign selects mean unsigned multiplication
// - single serves 10-18 bits, dual up to 9
`include "emb_mult_regs.svh"

module embedded_multiplier_block
	import emb_mult_pkg::*;
#(
	parameter mul_mode_t MODE = MODE_SINGLE,
	parameter int A_WIDTH = 18,
	parameter int B_WIDTH = 18,
	parameter bit A_REG = 1'b1,
	parameter bit B_REG = 1'b1,
	parameter bit SIGN_A_REG = 1'b1,
	parameter bit SIGN_B_REG = 1'b1,
	parameter bit OUT_REG = 1'b1,
	parameter bit SIGN_USED = 1'b1
)
(
	input wire logic i_core_clk, // block clock
	input wire logic i_reset, // synchronous reset, high
	input wire logic i_aclr, // asynchronous clear, high
	input wire logic i_ena, // shared clock enable, high
	input wire logic [17:0] i_data_a, // operand a, two 9-bit in dual
	input wire logic [17:0] i_data_b, // operand b, two 9-bit in dual
	input wire logic i_sign_a, // operand a signed when high
	input wire logic i_sign_b, // operand b signed when high
	output logic [35:0] o_result, // product, two halves in dual
	output logic o_result_signed // product is signed
);

	// refuse widths the selected mode cannot serve
	if (A_WIDTH < 1 || A_WIDTH > `MUL_FULL_W ||
		B_WIDTH < 1 || B_WIDTH > `MUL_FULL_W)
	begin : g_bad_width
		$error("operand width out of range 1..18");
	end
	if (MODE == MODE_DUAL && (A_WIDTH > `MUL_SECT_W ||
		B_WIDTH > `MUL_SECT_W))
	begin : g_bad_dual
		$error("dual mode serves operands of at most 9 bits");
	end
	if (MODE == MODE_SINGLE && (A_WIDTH < `MUL_SINGLE_MIN_W ||
		B_WIDTH < `MUL_SINGLE_MIN_W))
	begin : g_bad_single
		$error("single mode serves operands of 10 to 18 bits");
	end

	// extend a w-bit operand to 18 bits as its sign select says
	function automatic logic [17:0] ext_op(input logic [17:0] v,
		input int w, input logic sgn);
		logic [17:0] r;
		r = v;
		for (int i = 0; i < 18; i++)
		begin
			if (i >= w)
			begin
				r[i] = sgn & v[w-1];
			end
		end
		return r;
	endfunction

	// full 36-bit product; a 19th bit carries the sign so every
	// signed/unsigned mix fits without loss
	function automatic logic [35:0] mul18(input logic [17:0] a,
		input logic [17:0] b, input logic sa, input logic sb);
		logic signed [18:0] ax;
		logic signed [18:0] bx;
		logic signed [37:0] p;
		ax = $signed({sa & a[17], a});
		bx = $signed({sb & b[17], b});
		p = ax * bx;
		return p[35:0];
	endfunction

	logic sign_a_in;
	logic sign_b_in;
	logic [17:0] a_r;
	logic [17:0] b_r;
	logic sa_r;
	logic sb_r;
	logic [17:0] a_q;
	logic [17:0] b_q;
	logic sa_q;
	logic sb_q;
	mul_result_t prod_nxt;
	logic [17:0] res_lo_r;
	logic [17:0] res_hi_r;
	logic sgn_r;

	// tie-off of unused selects gives unsigned operation
	assign sign_a_in = SIGN_USED ? i_sign_a : 1'b0;
	assign sign_b_in = SIGN_USED ? i_sign_b : 1'b0;

	// every register below shares clock, enable and clear
	always_ff @(posedge i_core_clk or posedge i_aclr)
	begin
		if (i_aclr)
		begin
			a_r <= 18'h0;
		end
		else if (i_reset)
		begin
			a_r <= 18'h0;
		end
		else if (i_ena)
		begin
			a_r <= i_data_a;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_aclr)
	begin
		if (i_aclr)
		begin
			b_r <= 18'h0;
		end
		else if (i_reset)
		begin
			b_r <= 18'h0;
		end
		else if (i_ena)
		begin
			b_r <= i_data_b;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_aclr)
	begin
		if (i_aclr)
		begin
			sa_r <= 1'b0;
			sb_r <= 1'b0;
		end
		else if (i_reset)
		begin
			sa_r <= 1'b0;
			sb_r <= 1'b0;
		end
		else if (i_ena)
		begin
			sa_r <= sign_a_in;
			sb_r <= sign_b_in;
		end
	end

	// per-input register-or-bypass choice
	assign a_q = A_REG ? a_r : i_data_a;
	assign b_q = B_REG ? b_r : i_data_b;
	// sign register should match its operand's latency
	assign sa_q = SIGN_A_REG ? sa_r : sign_a_in;
	assign sb_q = SIGN_B_REG ? sb_r : sign_b_in;

	always_comb
	begin
		if (MODE == MODE_DUAL)
		begin
			// halves never share carries: each is its own product
			prod_nxt[17:0] = 18'(mul18(ext_op({9'h0, a_q[8:0]},
				A_WIDTH, sa_q), ext_op({9'h0, b_q[8:0]}, B_WIDTH,
				sb_q), sa_q, sb_q));
			prod_nxt[35:18] = 18'(mul18(ext_op({9'h0, a_q[17:9]},
				A_WIDTH, sa_q), ext_op({9'h0, b_q[17:9]}, B_WIDTH,
				sb_q), sa_q, sb_q));
		end
		else
		begin
			prod_nxt = mul18(ext_op(a_q, A_WIDTH, sa_q),
				ext_op(b_q, B_WIDTH, sb_q), sa_q,
				sb_q);
		end
	end

	// two 18-bit output sections; in single mode they act as one
	always_ff @(posedge i_core_clk or posedge i_aclr)
	begin
		if (i_aclr)
		begin
			res_lo_r <= 18'h0;
			res_hi_r <= 18'h0;
			sgn_r <= 1'b0;
		end
		else if (i_reset)
		begin
			res_lo_r <= 18'h0;
			res_hi_r <= 18'h0;
			sgn_r <= 1'b0;
		end
		else if (i_ena)
		begin
			res_lo_r <= prod_nxt[17:0];
			res_hi_r <= prod_nxt[35:18];
			sgn_r <= sa_q | sb_q;
		end
	end

	assign o_result = OUT_REG ? {res_hi_r, res_lo_r} : prod_nxt;
	assign o_result_signed = OUT_REG ? sgn_r : (sa_q | sb_q);

	property p_out_reg;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		OUT_REG && i_ena |=> o_result == $past(prod_nxt);
	endproperty
	a_out_reg: assert property (p_out_reg)
		else $error("output register missed the product");

	property p_hold;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		OUT_REG && !i_ena |=> $stable(o_result) && $stable(o_result_signed);
	endproperty
	a_hold: assert property (p_hold)
		else $error("result moved while enable low");

	property p_a_reg;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		A_REG && i_ena |=> a_q == $past(i_data_a);
	endproperty
	a_a_reg: assert property (p_a_reg)
		else $error("operand a register did not load");
	property p_b_reg;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		B_REG && i_ena |=> b_q == $past(i_data_b);
	endproperty
	a_b_reg: assert property (p_b_reg)
		else $error("operand b register did not load");

	property p_sign_reg;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		SIGN_A_REG && SIGN_B_REG && i_ena ##1 !i_ena |=>
			sa_q == $past(sign_a_in, 2) && sb_q == $past(sign_b_in, 2);
	endproperty
	a_sign_reg: assert property (p_sign_reg)
		else $error("sign register lost its value");

	property p_unsigned;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		MODE == MODE_SINGLE && !sa_q && !sb_q |->
			prod_nxt == 36'(a_q & ((18'h1 << A_WIDTH) - 18'h1)) *
			36'(b_q & ((18'h1 << B_WIDTH) - 18'h1));
	endproperty
	a_unsigned: assert property (p_unsigned)
		else $error("unsigned product wrong");

	property p_signed;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		MODE == MODE_SINGLE && A_WIDTH == 18 && B_WIDTH == 18 &&
			sa_q && sb_q |->
			$signed(prod_nxt) == 36'($signed(a_q)) * 36'($signed(b_q));
	endproperty
	a_signed: assert property (p_signed)
		else $error("signed product wrong");

	property p_dual_indep;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		MODE == MODE_DUAL && !sa_q && !sb_q |->
			prod_nxt[17:0] == 18'(a_q[8:0]) * 18'(b_q[8:0]) &&
			prod_nxt[35:18] == 18'(a_q[17:9]) * 18'(b_q[17:9]);
	endproperty
	a_dual_indep: assert property (p_dual_indep)
		else $error("dual products not independent");

	property p_clear;
		@(posedge i_core_clk) disable iff (i_aclr)
		OUT_REG && i_reset |=> o_result == `MUL_CLR_VAL && !o_result_signed;
	endproperty
	a_clear: assert property (p_clear)
		else $error("reset did not clear the result");

	property p_no_sign;
		@(posedge i_core_clk) disable iff (i_aclr || i_reset)
		!SIGN_USED |-> !sa_q && !sb_q ##1 !o_result_signed;
	endproperty
	a_no_sign: assert property (p_no_sign)
		else $error("unused sign selects not unsigned");

	c_signed_single: cover property (@(posedge i_core_clk)
		MODE == MODE_SINGLE && sa_q && !sb_q && i_ena);
	c_dual: cover property (@(posedge i_core_clk)
		MODE == MODE_DUAL && sa_q && sb_q && i_ena);
	c_stall: cover property (@(posedge i_core_clk)
		i_ena ##1 !i_ena [*3] ##1 i_ena);

endmodule // embedded_multiplier_block

// *** fabric_model.sv ***
`timescale 1ns/1ps
module fabric_model
(
	input wire logic i_core_clk, // block clock
	output logic [17:0] o_data_a, // operand a
	output logic [17:0] o_data_b, // operand b
	output logic o_sign_a, // a signed when high
	output logic o_sign_b // b signed when high
);
	initial
	begin
		o_data_a = 18'h0;
		o_data_b = 18'h0;
		o_sign_a = 1'b0;
		o_sign_b = 1'b0;
	end

	// signs change with their operands, just after an edge
	task put(input logic [17:0] a, input logic [17:0] b,
		input logic sa, input logic sb);
	begin
		@(posedge i_core_clk);
		#1;
		o_data_a = a;
		o_data_b = b;
		o_sign_a = sa;
		o_sign_b = sb;
	end
	endtask
endmodule // fabric_model

// *** test_embedded_multiplier_block.sv ***
`timescale 1ns/1ps
module test_embedded_multiplier_block;
	import emb_mult_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_aclr = 1'b0;
	logic i_ena = 1'b1;
	logic [17:0] a, b;
	logic sa, sb, rs;
	mul_result_t res, dres;
	int fail_count = 0;
	int num_checks = 0;
	mul_result_t eq[$], dq[$];
	logic es[$];
	logic [17:0] va[4] = '{18'h3ffff, 18'h20000, 18'h0ff80, 18'h00001};
	logic [17:0] vb[4] = '{18'h3ffff, 18'h1ffff, 18'h2017f, 18'h3fffe};

	always #12.5 i_core_clk = ~i_core_clk;

	fabric_model i_fab (.i_core_clk(i_core_clk), .o_data_a(a),
		.o_data_b(b), .o_sign_a(sa), .o_sign_b(sb));
	embedded_multiplier_block i_dut (.i_core_clk(i_core_clk),
		.i_reset(i_reset), .i_aclr(i_aclr), .i_ena(i_ena),
		.i_data_a(a), .i_data_b(b), .i_sign_a(sa), .i_sign_b(sb),
		.o_result(res), .o_result_signed(rs));
	// dual, inputs registered, product unregistered: one cycle
	embedded_multiplier_block #(.MODE(MODE_DUAL), .A_WIDTH(9),
		.B_WIDTH(9), .OUT_REG(1'b0)) i_dual (.i_core_clk(i_core_clk),
		.i_reset(i_reset), .i_aclr(i_aclr), .i_ena(i_ena),
		.i_data_a(a), .i_data_b(b), .i_sign_a(sa), .i_sign_b(sb),
		.o_result(dres), .o_result_signed());

	function automatic mul_result_t e_full(logic [17:0] x, logic [17:0] y,
		logic p, logic q);
		logic signed [37:0] r;
		r = $signed({p & x[17], x}) * $signed({q & y[17], y});
		return r[35:0];
	endfunction

	function automatic logic [17:0] e_half(logic [8:0] x, logic [8:0] y,
		logic p, logic q);
		logic signed [19:0] r;
		r = $signed({p & x[8], x}) * $signed({q & y[8], y});
		return r[17:0];
	endfunction

	task chk(input mul_result_t got, input mul_result_t exp);
	begin
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task op(input logic [17:0] x, input logic [17:0] y,
		input logic p, input logic q);
	begin
		i_fab.put(x, y, p, q);
		eq.push_back(e_full(x, y, p, q));
		es.push_back(p | q);
		dq.push_back({e_half(x[17:9], y[17:9], p, q),
			e_half(x[8:0], y[8:0], p, q)});
		if (eq.size() > 2)
		begin
			chk(res, eq.pop_front());
			chk({35'h0, rs}, {35'h0, es.pop_front()});
		end
		if (dq.size() > 1)
			chk(dres, dq.pop_front());
	end
	endtask

	task end_sim;
	begin
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	initial
	begin
		#(25 * 2000);
		fail_count++;
		end_sim();
	end

	initial
	begin
		repeat (10) @(posedge i_core_clk);
		#1 i_reset = 1'b0;
		// sign b flips every cycle, sign a every second cycle, back to back
		for (int i = 0; i < 4; i++)
			for (int s = 0; s < 4; s++)
				op(va[i], vb[i], s[1], s[0]);
		$display("test sign mix done");
		repeat (3) op(va[2], vb[2], 1'b1, 1'b0);
		i_ena = 1'b0;
		repeat (3) i_fab.put(va[0], vb[0], 1'b1, 1'b1);
		chk(res, e_full(va[2], vb[2], 1'b1, 1'b0));
		chk(dres, {e_half(va[2][17:9], vb[2][17:9], 1'b1, 1'b0),
			e_half(va[2][8:0], vb[2][8:0], 1'b1, 1'b0)});
		$display("test enable hold done");
		i_aclr = 1'b1;
		#1 chk(res, 36'h0);
		chk(dres, 36'h0);
		@(posedge i_core_clk);
		#1 i_aclr = 1'b0;
		i_ena = 1'b1;
		eq.delete();
		es.delete();
		dq.delete();
		repeat (3) op(va[1], vb[1], 1'b0, 1'b1);
		i_reset = 1'b1;
		@(posedge i_core_clk);
		#1 chk(res, 36'h0);
		chk(dres, 36'h0);
		i_reset = 1'b0;
		$display("test clear done");
		end_sim();
	end
endmodule // test_embedded_multiplier_block
